// [hdl/mtc_crc32.v]
// Purpose: one byte step of the ethernet crc-32
// Assumes: reflected polynomial, lsb of each byte first
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module mtc_crc32 (
    input wire [31:0] crc_in,
    input wire [7:0] data_in,
    output reg [31:0] crc_out
);
    integer i;
    reg [31:0] c;
    always @* begin
        c = crc_in;
        for (i = 0; i < 8; i = i + 1) begin
            if (c[0] ^ data_in[i])
                c = (c >> 1) ^ 32'hEDB8_8320;
            else
                c = c >> 1;
        end
        crc_out = c;
    end
endmodule // mtc_crc32
`default_nettype wire

// [hdl/mtc_defs.vh]
// Purpose: constants for the transmit count, hash filter and buffer port
// Assumes: Avalon-MM word addressing, one 32-bit word per register
// Notes: definitions only
`ifndef MTC_DEFS_VH
`define MTC_DEFS_VH
`define MTC_A_BITCNT_LO 4'h0
`define MTC_A_BITCNT_HI 4'h1
`define MTC_A_HASH_BASE 4'h2
`define MTC_A_DATA_PORT 4'hA
`define MTC_A_TX_START 4'hB
`define MTC_A_CTRL 4'hC
`define MTC_A_IRQ_STAT 4'hD
`define MTC_A_IRQ_MASK 4'hE
`define MTC_BITCNT_W 14
`define MTC_BITCNT_MAX 14'h3FFF
`define MTC_CTRL_EN 7
`define MTC_CTRL_SWAP 0
`define MTC_CTRL_WIDE 1
`define MTC_CTRL_MODE_LO 2
`define MTC_MODE_HASH 2'h2
`define MTC_TXGO_BIT 7
`define MTC_IRQ_DONE 0
`define MTC_IRQ_ALL 1
`define MTC_IRQ_STOP 2
`define MTC_CNT_ZERO 7'h00
`define MTC_ZERO8 8'h00
`endif

// [hdl/mtc_top.v]
// Purpose: bit counter, multicast hash filter, buffer port, tx start
// Assumes: single clock, synchronous high reset, avalon-mm slave
// Notes: engine side signals are one-cycle pulses from the tx/rx logic
// Notes on behaviour
// - bit counter cleared at start, counts until collision
// - counter read-only, high byte bits 7:6 zero
// - hash decides only when match mode is 10
// - crc-32 of address, six low bits pick group
// - accept multicast when selected hash bit set
// - hash bytes get no reset value
// - hash access only while link enable set
// - data port 8 or 16 bits by bus mode
// - byte swap on data port when enabled, 16-bit mode only
// - start bit launches, zero ignored, reads pending count
// - pending count decrements per sent frame
// - one start sends all queued frames
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defs.vh"
module mtc_top (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg irq,
    input wire tx_bit_tick,
    input wire tx_frame_start,
    input wire tx_stop_event,
    input wire tx_frame_done,
    output reg tx_go_pulse,
    output reg [6:0] tx_pending_q,
    input wire rx_addr_valid,
    input wire [7:0] rx_addr_byte,
    input wire rx_addr_first,
    input wire rx_addr_last,
    input wire [1:0] receive_mode,
    output reg rx_hash_valid,
    output reg rx_hash_accept,
    output reg buf_wr,
    output reg buf_rd,
    output reg buf_wide,
    output reg [15:0] buf_wdata,
    input wire [15:0] buf_rdata
);
    reg [13:0] bitcnt_q;
    reg counting_q;
    reg [7:0] hash_q [0:7];
    reg [7:0] ctrl_q;
    reg [2:0] stat_q;
    reg [2:0] mask_q;
    reg [31:0] crc_q;
    reg [5:0] group_q;
    reg done_ph_q;
    reg [31:0] crc_next;
    wire [31:0] crc_seed;
    wire access;
    wire hash_sel;
    wire [2:0] hash_idx;
    wire [3:0] hash_off;
    wire [2:0] ev;
    reg [15:0] port_rd;
    reg [31:0] rd_d;
    assign access = (avs_read | avs_write) & avs_waitrequest;
    assign hash_sel = (avs_address >= `MTC_A_HASH_BASE) &&
                      (avs_address < `MTC_A_DATA_PORT);
    // subtract on the full address, then keep the byte index bits
    assign hash_off = avs_address - `MTC_A_HASH_BASE;
    assign hash_idx = hash_off[2:0];
    assign crc_seed = rx_addr_first ? 32'hFFFF_FFFF : crc_q;
    mtc_crc32 u_crc (
        .crc_in(crc_seed),
        .data_in(rx_addr_byte),
        .crc_out(crc_next)
    );
    // answer every access in its second cycle; one wait state
    always @(posedge clk) begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else if (access & ~avs_waitrequest)
            avs_waitrequest <= 1'b1;
        else if ((avs_read | avs_write) & avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end
    wire take;
    assign take = (avs_read | avs_write) & ~avs_waitrequest;
    wire wr_take;
    assign wr_take = take & avs_write;
    // counter holds once collision or carrier loss seen
    always @(posedge clk) begin
        if (sys_rst) begin
            bitcnt_q <= 14'h0000;
            counting_q <= 1'b0;
        end else if (tx_frame_start) begin
            bitcnt_q <= 14'h0000;
            counting_q <= 1'b1;
        end else if (tx_stop_event) begin
            counting_q <= 1'b0;
        end else if (counting_q & tx_bit_tick &
                     (bitcnt_q != `MTC_BITCNT_MAX)) begin
            bitcnt_q <= bitcnt_q + 14'h0001;
        end
    end
    // no reset branch: contents undefined until software loads them
    always @(posedge clk) begin
        if (wr_take & hash_sel & avs_byteenable[0] &
            ctrl_q[`MTC_CTRL_EN])
            hash_q[hash_idx] <= avs_writedata[7:0];
    end
    // control: enable, swap, bus width; the hash match mode comes from the receive_mode input
    always @(posedge clk) begin
        if (sys_rst)
            ctrl_q <= `MTC_ZERO8;
        else if (wr_take && avs_address == `MTC_A_CTRL && avs_byteenable[0])
            ctrl_q <= avs_writedata[7:0];
    end
    // start command and pending frame count
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_pending_q <= `MTC_CNT_ZERO;
            tx_go_pulse <= 1'b0;
        end else begin
            tx_go_pulse <= 1'b0;
            if (wr_take && avs_address == `MTC_A_TX_START &&
                avs_byteenable[0] && avs_writedata[`MTC_TXGO_BIT]) begin
                tx_go_pulse <= 1'b1;
                tx_pending_q <= avs_writedata[6:0];
            end else if (tx_frame_done && tx_pending_q != `MTC_CNT_ZERO) begin
                tx_pending_q <= tx_pending_q - 7'h01;
            end
        end
    end
    // events: frame done, all sent, collision/carrier stop
    assign ev[`MTC_IRQ_DONE] = tx_frame_done;
    assign ev[`MTC_IRQ_ALL] = tx_frame_done & (tx_pending_q == 7'h01);
    assign ev[`MTC_IRQ_STOP] = tx_stop_event & counting_q;
    always @(posedge clk) begin
        if (sys_rst) begin
            stat_q <= 3'h0;
            mask_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            // a new event wins over a simultaneous clear
            if (wr_take && avs_address == `MTC_A_IRQ_STAT && avs_byteenable[0])
                stat_q <= (stat_q & ~avs_writedata[2:0]) | ev;
            else
                stat_q <= stat_q | ev;
            if (wr_take && avs_address == `MTC_A_IRQ_MASK && avs_byteenable[0])
                mask_q <= avs_writedata[2:0];
            irq <= |((stat_q | ev) & mask_q);
        end
    end
    // hash lookup over the destination address stream
    always @(posedge clk) begin
        if (sys_rst) begin
            crc_q <= 32'hFFFF_FFFF;
            group_q <= 6'h00;
            done_ph_q <= 1'b0;
            rx_hash_valid <= 1'b0;
            rx_hash_accept <= 1'b0;
        end else begin
            rx_hash_valid <= 1'b0;
            done_ph_q <= 1'b0;
            if (rx_addr_valid) begin
                crc_q <= crc_next;
                if (rx_addr_last) begin
                    group_q <= crc_next[5:0];
                    done_ph_q <= 1'b1;
                end
            end
            if (done_ph_q) begin
                rx_hash_valid <= 1'b1;
                // only in hash mode; other modes never accept here
                rx_hash_accept <= (receive_mode == `MTC_MODE_HASH) &&
                    hash_q[group_q[5:3]][group_q[2:0]];
            end
        end
    end
    // buffer port with optional byte exchange
    always @(posedge clk) begin
        if (sys_rst) begin
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_wide <= 1'b0;
            buf_wdata <= 16'h0000;
        end else begin
            buf_wide <= ctrl_q[`MTC_CTRL_WIDE];
            buf_wr <= wr_take && avs_address == `MTC_A_DATA_PORT;
            buf_rd <= take & avs_read && avs_address == `MTC_A_DATA_PORT;
            if (wr_take && avs_address == `MTC_A_DATA_PORT) begin
                if (!ctrl_q[`MTC_CTRL_WIDE])
                    buf_wdata <= {`MTC_ZERO8, avs_writedata[7:0]};
                else if (ctrl_q[`MTC_CTRL_SWAP])
                    buf_wdata <= {avs_writedata[7:0],
                                  avs_writedata[15:8]};
                else
                    buf_wdata <= avs_writedata[15:0];
            end
        end
    end
    always @* begin
        if (!ctrl_q[`MTC_CTRL_WIDE])
            port_rd = {`MTC_ZERO8, buf_rdata[7:0]};
        else if (ctrl_q[`MTC_CTRL_SWAP])
            port_rd = {buf_rdata[7:0], buf_rdata[15:8]};
        else
            port_rd = buf_rdata;
    end
    always @* begin
        rd_d = 32'h0000_0000;
        if (hash_sel) begin
            if (ctrl_q[`MTC_CTRL_EN])
                rd_d = {24'h00_0000, hash_q[hash_idx]};
        end else begin
            case (avs_address)
                `MTC_A_BITCNT_LO: rd_d = {24'h00_0000, bitcnt_q[7:0]};
                `MTC_A_BITCNT_HI: rd_d = {26'h000_0000, bitcnt_q[13:8]};
                `MTC_A_DATA_PORT: rd_d = {16'h0000, port_rd};
                `MTC_A_TX_START: rd_d = {24'h00_0000, 1'b0, tx_pending_q};
                `MTC_A_CTRL: rd_d = {24'h00_0000, ctrl_q};
                `MTC_A_IRQ_STAT: rd_d = {29'h0000_0000, stat_q};
                `MTC_A_IRQ_MASK: rd_d = {29'h0000_0000, mask_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end
    always @(posedge clk) begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & avs_waitrequest)
            avs_readdata <= rd_d;
    end
endmodule // mtc_top
`default_nettype wire

// [test/mac_tx_count_hash_port_bench.sv]
// Purpose: register level tests of mtc_top
// Assumes: avalon-mm master tasks, buffer word model
// Notes: hash tested with all-set and all-clear tables
`timescale 1ns/1ps
`default_nettype none
module mac_tx_count_hash_port_bench;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic avs_waitrequest, irq, tx_go_pulse, rx_hash_valid, rx_hash_accept;
    logic buf_wr, buf_rd, buf_wide, rx_addr_last = 0, rx_addr_first = 0;
    logic tx_bit_tick = 0, tx_frame_start = 0, tx_stop_event = 0;
    logic tx_frame_done = 0, rx_addr_valid = 0;
    logic [6:0] tx_pending_q;
    logic [15:0] buf_wdata, buf_rdata;
    logic [7:0] rx_addr_byte = 8'h00;
    logic [1:0] receive_mode = 2'h0;
    int num_errors = 0, total_checks = 0;
    mtc_top i_mtc_top (.*);
    mtc_buf_model i_mtc_buf_model (.clk, .buf_wr, .buf_wdata, .buf_rdata);
    always #20 clk = ~clk;
    task chk(input [31:0] g, input [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t got %h want %h", $time, g, e);
        end
    endtask
    // reads compare to e; the master holds until waitrequest is low
    task bus(input w, input [3:0] a, input [31:0] d, input [31:0] e);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        if (!w) chk(avs_readdata, e);
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task frame(input [1:0] m, input e);
        receive_mode <= m;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            rx_addr_valid <= 1;
            rx_addr_byte <= 8'h01 + 8'(i);
            rx_addr_first <= i == 0;
            rx_addr_last <= i == 5;
        end
        @(posedge clk);
        rx_addr_valid <= 0;
        @(posedge clk);
        @(negedge clk);
        chk(rx_hash_valid, 1);
        chk(rx_hash_accept, e);
    endtask
    task fill(input [7:0] v);
        for (int i = 2; i < 10; i++) bus(1, 4'(i), v, 0);
    endtask
    task close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100_000;
        num_errors++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        bus(0, 4'h2, 0, 8'h00);
        bus(0, 4'hF, 0, 8'h00);
        bus(1, 4'hC, 8'h80, 0);
        fill(8'hFF);
        bus(1, 4'hC, 8'h00, 0);
        bus(1, 4'h5, 8'h00, 0);
        bus(1, 4'hC, 8'h80, 0);
        bus(0, 4'h5, 0, 8'hFF);
        frame(2'h2, 1);
        frame(2'h1, 0);
        fill(8'h00);
        frame(2'h2, 0);
        @(posedge clk);
        tx_frame_start <= 1;
        @(posedge clk);
        tx_frame_start <= 0;
        tx_bit_tick <= 1;
        repeat (261) @(posedge clk);
        tx_bit_tick <= 0;
        tx_stop_event <= 1;
        @(posedge clk);
        tx_stop_event <= 0;
        tx_bit_tick <= 1;
        repeat (3) @(posedge clk);
        tx_bit_tick <= 0;
        bus(0, 4'h0, 0, 8'h05);
        bus(0, 4'h1, 0, 8'h01);
        bus(1, 4'h0, 8'hFF, 0);
        bus(0, 4'h0, 0, 8'h05);
        bus(1, 4'hC, 8'h83, 0);
        bus(1, 4'hA, 16'hABCD, 0);
        bus(0, 4'hA, 0, 16'hABCD);
        chk(buf_rdata, 16'hCDAB);
        bus(1, 4'hC, 8'h82, 0);
        bus(0, 4'hA, 0, 16'hCDAB);
        bus(1, 4'hC, 8'h80, 0);
        bus(0, 4'hA, 0, 8'hAB);
        bus(1, 4'hE, 8'h02, 0);
        bus(1, 4'hB, 8'h83, 0);
        bus(0, 4'hB, 0, 8'h03);
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk);
            tx_frame_done <= 1;
            @(posedge clk);
            tx_frame_done <= 0;
            @(posedge clk);
            chk(tx_pending_q, i);
        end
        repeat (2) @(posedge clk);
        chk(irq, 1);
        bus(0, 4'hD, 0, 8'h07);
        bus(1, 4'hD, 8'h03, 0);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        close_out;
    end
endmodule // mac_tx_count_hash_port_bench
`default_nettype wire

// [test/mtc_buf_model.sv]
// Purpose: one word of buffer memory behind the data port
// Assumes: write strobe is a one-cycle pulse
// Notes: a single word suffices to see lane order
`timescale 1ns/1ps
`default_nettype none
module mtc_buf_model (
    input wire logic clk,
    input wire logic buf_wr,
    input wire logic [15:0] buf_wdata,
    output var logic [15:0] buf_rdata
);
    initial buf_rdata = 16'h1234;
    always @(posedge clk) begin
        if (buf_wr) begin
            buf_rdata <= buf_wdata;
        end
    end
endmodule // mtc_buf_model
`default_nettype wire

// [test/mtc_monitor.sv]
// Purpose: port checker for mtc_top
// Assumes: one clock, sync high reset
// Notes: bound to every mtc_top below
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defs.vh"
module mtc_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic tx_frame_done,
    input wire logic tx_go_pulse,
    input wire logic [6:0] tx_pending_q,
    input wire logic rx_addr_valid,
    input wire logic rx_addr_last,
    input wire logic [1:0] receive_mode,
    input wire logic rx_hash_valid,
    input wire logic rx_hash_accept
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic ack = !avs_waitrequest;
    wire logic wr_b = avs_write && ack && avs_byteenable[0]
        && avs_address == `MTC_A_TX_START;
    wire logic go = wr_b && avs_writedata[7];
    wire logic last = rx_addr_valid && rx_addr_last;
    a_bus_ack: assert property ((avs_read || avs_write) && !ack |=> ack)
        else $error("no ack after request");
    a_go_pulse: assert property (go |=> tx_go_pulse)
        else $error("start write gave no pulse");
    a_go_cause: assert property (tx_go_pulse |-> $past(go))
        else $error("pulse without start write");
    a_count_load: assert property (go |=> tx_pending_q == $past(avs_writedata[6:0]))
        else $error("count not loaded");
    a_count_dec: assert property (tx_frame_done && tx_pending_q != 7'h00 && !wr_b
        |=> tx_pending_q == $past(tx_pending_q) - 7'h01)
        else $error("count not decremented");
    a_count_rest: assert property (tx_pending_q == 7'h00 && !wr_b |=> tx_pending_q == 7'h00)
        else $error("count left zero");
    a_hash_valid: assert property (last |-> ##2 rx_hash_valid)
        else $error("no hash verdict");
    a_hash_cause: assert property (rx_hash_valid |-> $past(last, 2))
        else $error("stray hash verdict");
    a_hash_mode: assert property (last && receive_mode != `MTC_MODE_HASH
        |-> ##2 !rx_hash_accept)
        else $error("accept outside hash mode");
    c_go: cover property (go);
    c_last: cover property (tx_frame_done && tx_pending_q == 7'h01);
    c_acc: cover property (rx_hash_valid && rx_hash_accept);
endmodule // mtc_monitor
bind mtc_top mtc_monitor i_mtc_monitor (.*);
`default_nettype wire
